// file: include/shift_pkg.sv
// shared constants and types for the parallel-load serial shift register
package shift_pkg;

	// =====================================================================
	// geometry
	localparam int STAGE_COUNT = 8;
	localparam int OUT_A_IDX = 5; // sixth stage
	localparam int OUT_B_IDX = 6; // seventh stage
	localparam int OUT_C_IDX = 7; // eighth stage
	localparam int SYNC_DEPTH = 2;
	localparam int FIFO_DEPTH = 16;

	// =====================================================================
	// fill tracking: contents are known after a load or this many shifts
	localparam logic [3:0] FILL_SHIFTS = 4'h8;
	localparam logic [3:0] FILL_RESET = 4'h0;

	// =====================================================================
	// reset values of control state
	localparam logic SYNC_RESET = 1'b0;
	localparam logic FLAG_RESET = 1'b0;

	typedef logic [STAGE_COUNT-1:0] stage_t;

	// kind of change that the sampled pins request
	typedef enum logic {
		OP_SHIFT,
		OP_LOAD
	} op_e;

	// one pin event travelling through the buffer
	typedef struct packed {
		op_e op;
		logic serial_bit;
		stage_t parallel_bits;
	} event_s;

	localparam int EVENT_WIDTH = $bits(event_s);

	// snapshot of the whole chain handed to the user side
	typedef struct packed {
		op_e op;
		stage_t stages;
	} snapshot_s;

endpackage

// file: core/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync import shift_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;

	// =====================================================================
	// first flop is read only by the second
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_r <= {WIDTH{SYNC_RESET}};
			sync_o <= {WIDTH{SYNC_RESET}};
		end else begin
			meta_r <= pin_i;
			sync_o <= meta_r;
		end
	end

endmodule // pin_sync

// file: core/event_fifo.sv
// flop-based fifo with valid/ready on both sides
`timescale 1ns/1ps
module event_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// =====================================================================
	// handshake terms
	assign in_ready_o = (count_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem_r[rd_ptr_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// storage is data only, so it carries no reset
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
			if (push && !pop) begin
				count_r <= count_r + (AW+1)'(1);
			end else if (pop && !push) begin
				count_r <= count_r - (AW+1)'(1);
			end
		end
	end

endmodule // event_fifo

// file: core/shift_register.sv
// eight-stage shift register with serial shift and parallel load
`timescale 1ns/1ps
module shift_register import shift_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic shift_clock_i,
	input wire logic load_select_i,
	input wire logic serial_in_i,
	input wire logic [STAGE_COUNT-1:0] parallel_in_i,
	output logic stage6_out_o,
	output logic stage7_out_o,
	output logic stage8_out_o,
	output logic contents_known_o,
	output logic snap_valid_o,
	input wire logic snap_ready_i,
	output snapshot_s snap_data_o,
	output logic overflow_o,
	input wire logic overflow_clear_i
);

	// =====================================================================
	// internal signals

	// synchronised pins
	logic clk_sync;
	logic load_sync;
	logic serial_sync;
	stage_t par_sync;

	// history of the synchronised pins
	logic clk_prev_r;
	logic load_prev_r;
	stage_t par_prev_r;

	// event generation
	logic shift_edge;
	logic load_event;
	logic ev_valid;
	event_s ev_word;
	logic fifo_in_ready;

	// buffer drain side
	logic fifo_out_valid;
	event_s fifo_out_word;
	logic apply;

	// event kind, slot state and loss
	op_e ev_op;
	logic slot_free;
	logic lost_event;

	// the chain itself
	stage_t stages_r;
	stage_t stages_nxt;
	logic [3:0] fill_r;
	logic [3:0] fill_nxt;

	// =====================================================================
	// functions

	// next chain contents for one event; bit 0 is stage one
	// the default arm only guards an unknown op read from the buffer
	function automatic stage_t chain_step(input stage_t cur, input event_s ev);
		stage_t res;
		res = cur;
		case (ev.op)
			OP_LOAD: begin
				res = ev.parallel_bits;
			end
			OP_SHIFT: begin
				res = {cur[STAGE_COUNT-2:0], ev.serial_bit};
			end
			default: begin
				res = cur;
			end
		endcase
		return res;
	endfunction

	// count of shifts since reset; a load sets it straight to eight
	// saturates at eight so a long run of shifts never wraps to zero
	function automatic logic [3:0] fill_step(input logic [3:0] cur, input event_s ev);
		logic [3:0] res;
		res = cur;
		if (ev.op == OP_LOAD) begin
			res = FILL_SHIFTS;
		end else if (cur != FILL_SHIFTS) begin
			res = cur + 4'h1;
		end
		return res;
	endfunction

	// =====================================================================
	// pin synchronisers
	// the parallel bus is caught bit by bit, so a word that changes
	// under load select may land skewed; a skewed word lasts one
	// cycle and is then replaced by the settled word
	// every pin pays two cycles of latency here, the price of a clean sample

	pin_sync #(
		.WIDTH(1)
	) u_sync_clk (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pin_i(shift_clock_i),
		.sync_o(clk_sync)
	);

	pin_sync #(
		.WIDTH(1)
	) u_sync_load (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pin_i(load_select_i),
		.sync_o(load_sync)
	);

	pin_sync #(
		.WIDTH(1)
	) u_sync_serial (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pin_i(serial_in_i),
		.sync_o(serial_sync)
	);

	pin_sync #(
		.WIDTH(STAGE_COUNT)
	) u_sync_par (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pin_i(parallel_in_i),
		.sync_o(par_sync)
	);

	// =====================================================================
	// pin history for edge and change detection

	// previous shift clock level; reset low so a high level at release
	// looks like an edge even though it did not rise after the release
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			clk_prev_r <= SYNC_RESET;
		end else begin
			clk_prev_r <= clk_sync;
		end
	end

	// previous load select level and parallel word
	// a load select already high at release therefore counts as a fresh load
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			load_prev_r <= SYNC_RESET;
			par_prev_r <= '0;
		end else begin
			load_prev_r <= load_sync;
			par_prev_r <= par_sync;
		end
	end

	// =====================================================================
	// event generation
	// a load is transparent: it is re-issued whenever the parallel word
	// moves while load select stays high, which gives the chain the
	// follow-the-inputs behaviour of an asynchronous load
	// a shift clock level must last one cycle to be seen; shorter pulses
	// are lost, which bounds the rate at which the host may shift
	assign shift_edge = clk_sync && !clk_prev_r;
	assign load_event = load_sync && (!load_prev_r || (par_sync != par_prev_r));
	// clock edges under load are dropped outright
	assign ev_valid = load_event || (shift_edge && !load_sync);
	// kind of event the pins ask for in this cycle
	assign ev_op = load_sync ? OP_LOAD : OP_SHIFT;

	// event word offered to the buffer
	always_comb begin
		ev_word = '0;
		ev_word.op = ev_op;
		ev_word.serial_bit = serial_sync;
		ev_word.parallel_bits = par_sync;
	end

	// =====================================================================
	// event buffer
	// the user-side snapshot stream can stall, so events wait here
	// sixteen entries ride out two full bytes of shifts behind a stall
	// events leave in order, so a load never overtakes an earlier shift

	event_fifo #(
		.WIDTH(EVENT_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(ev_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(ev_word),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(apply),
		.out_data_o(fifo_out_word)
	);

	// an event is applied only when the snapshot slot can take its result;
	// the chain waits with the slot so every snapshot matches the outputs
	assign slot_free = !snap_valid_o || snap_ready_i;
	assign apply = fifo_out_valid && slot_free;

	// =====================================================================
	// overflow flag
	// pins cannot be held off, so a full buffer loses the event; the flag
	// tells the user side; a new loss wins over a clear in the same cycle
	assign lost_event = ev_valid && !fifo_in_ready;

	// sticky loss flag
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			overflow_o <= FLAG_RESET;
		end else if (lost_event) begin
			overflow_o <= 1'b1;
		end else if (overflow_clear_i) begin
			overflow_o <= 1'b0;
		end
	end

	// =====================================================================
	// the chain
	// outputs trail the pins by four cycles, more while the snapshot
	// stream stalls; a host that reads them back must allow for that

	// next state of the chain and of the fill count
	always_comb begin
		stages_nxt = stages_r;
		fill_nxt = fill_r;
		if (apply) begin
			stages_nxt = chain_step(stages_r, fifo_out_word);
			fill_nxt = fill_step(fill_r, fifo_out_word);
		end
	end

	// storage stages carry no reset: their contents are data
	always_ff @(posedge clk_i) begin
		stages_r <= stages_nxt;
	end

	// fill count restarts with reset since nothing known is held then
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fill_r <= FILL_RESET;
		end else begin
			fill_r <= fill_nxt;
		end
	end

	// =====================================================================
	// outputs

	// not reset: these show unknown until a load or six, seven and eight shifts land
	// last three stages only; taken from the next value so they change
	// at the same edge as the chain
	always_ff @(posedge clk_i) begin
		stage6_out_o <= stages_nxt[OUT_A_IDX];
		stage7_out_o <= stages_nxt[OUT_B_IDX];
		stage8_out_o <= stages_nxt[OUT_C_IDX];
	end

	// contents known once loaded or fully shifted through
	// a mid-run reset drops it although the chain keeps its data
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			contents_known_o <= FLAG_RESET;
		end else begin
			contents_known_o <= (fill_nxt == FILL_SHIFTS);
		end
	end

	// snapshot stream: one word per applied event
	// valid stays high across back-to-back words while ready is high
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			snap_valid_o <= FLAG_RESET;
		end else if (apply) begin
			snap_valid_o <= 1'b1;
		end else if (snap_ready_i) begin
			snap_valid_o <= 1'b0;
		end
	end

	// snapshot data is held while it waits
	// the op field tells the user which kind of event made this word
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			snap_data_o <= '0;
		end else if (apply) begin
			snap_data_o.op <= fifo_out_word.op;
			snap_data_o.stages <= stages_nxt;
		end
	end

endmodule // shift_register

// file: tb/shift_register_checker.sv
// port-level assertions for the shift register
`timescale 1ns/1ps
module shift_register_checker import shift_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic shift_clock_i,
	input wire logic load_select_i,
	input wire logic serial_in_i,
	input wire logic [STAGE_COUNT-1:0] parallel_in_i,
	input wire logic stage6_out_o,
	input wire logic stage7_out_o,
	input wire logic stage8_out_o,
	input wire logic contents_known_o,
	input wire logic snap_valid_o,
	input wire logic snap_ready_i,
	input wire snapshot_s snap_data_o,
	input wire logic overflow_o,
	input wire logic overflow_clear_i
);
	// =====================================================================
	// quiet tracking
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic [7:0] quiet_r;
	// idle pins with a draining consumer; 24 cycles covers a full backlog of 16
	always_ff @(posedge clk_i) begin
		if (reset_i || !snap_ready_i || $changed(load_select_i) ||
			(load_select_i && $changed(parallel_in_i)) ||
			($rose(shift_clock_i) && !load_select_i)) quiet_r <= 8'h00;
		else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
	end

	// =====================================================================
	// assertions
	chk_reset_clears: assert property (disable iff (1'b0) reset_i
		|=> !snap_valid_o && !overflow_o && !contents_known_o)
		else $error("flags not cleared by reset");
	chk_quiet_hold: assert property (quiet_r > 8'h18 && contents_known_o
		|-> $stable({stage6_out_o, stage7_out_o, stage8_out_o}) && !snap_valid_o)
		else $error("stages moved without a shift or load");
	chk_shift_chain: assert property (snap_valid_o && snap_data_o.op == OP_SHIFT
		&& (!$past(snap_valid_o) || $past(snap_ready_i)) && $past(contents_known_o)
		|-> stage7_out_o == $past(stage6_out_o) && stage8_out_o == $past(stage7_out_o))
		else $error("shift did not move stages along");
	chk_outs_match: assert property (snap_valid_o && contents_known_o
		|-> {stage8_out_o, stage7_out_o, stage6_out_o} ==
		snap_data_o.stages[OUT_C_IDX:OUT_A_IDX])
		else $error("outputs differ from snapshot");
	chk_load_known: assert property (snap_valid_o && snap_data_o.op == OP_LOAD
		|-> contents_known_o)
		else $error("load did not mark contents known");
	chk_known_sticky: assert property (contents_known_o |=> contents_known_o)
		else $error("contents known dropped");
	chk_snap_hold: assert property (snap_valid_o && !snap_ready_i
		|=> snap_valid_o && $stable(snap_data_o))
		else $error("snapshot changed before taken");
	chk_ovf_sticky: assert property (overflow_o && !overflow_clear_i |=> overflow_o)
		else $error("overflow dropped without clear");
	cover property (snap_valid_o && snap_ready_i && snap_data_o.op == OP_SHIFT);
	cover property (snap_valid_o && snap_ready_i && snap_data_o.op == OP_LOAD);
	cover property ($rose(overflow_o));
endmodule // shift_register_checker

bind shift_register shift_register_checker chk (.clk_i, .reset_i, .shift_clock_i,
	.load_select_i, .serial_in_i, .parallel_in_i, .stage6_out_o, .stage7_out_o,
	.stage8_out_o, .contents_known_o, .snap_valid_o, .snap_ready_i, .snap_data_o,
	.overflow_o, .overflow_clear_i);

// file: tb/host_pins.sv
// host logic model driving the shift register pins
`timescale 1ns/1ps
module host_pins import shift_pkg::*; (
	input wire logic clk_i,
	output logic shift_clock_o,
	output logic load_select_o,
	output logic serial_o,
	output stage_t parallel_o
);
	logic busy;
	initial begin
		busy = 1'b0;
		shift_clock_o = 1'b0;
		load_select_o = 1'b0;
		serial_o = 1'b0;
		parallel_o = 8'h00;
	end
	// don't-care lines keep moving so a stale value can never pass
	always @(negedge clk_i) begin
		if (!busy) begin
			serial_o <= ~serial_o;
			parallel_o <= ~parallel_o;
		end
	end
	// one shift: data first, then clock high and low for hold cycles each
	task automatic shift(input logic b, input int hold);
		busy = 1'b1;
		@(negedge clk_i);
		serial_o <= b;
		repeat (hold) @(negedge clk_i);
		shift_clock_o <= 1'b1;
		repeat (hold) @(negedge clk_i);
		shift_clock_o <= 1'b0;
		repeat (hold) @(negedge clk_i);
		busy = 1'b0;
	endtask
	// parallel load; the clock keeps toggling to prove it is isolated
	task automatic load(input stage_t w, input int hold);
		busy = 1'b1;
		@(negedge clk_i);
		parallel_o <= w;
		load_select_o <= 1'b1;
		repeat (hold) begin
			repeat (2) @(negedge clk_i);
			shift_clock_o <= ~shift_clock_o;
		end
		repeat (2) @(negedge clk_i);
		shift_clock_o <= 1'b0;
		repeat (2) @(negedge clk_i);
		load_select_o <= 1'b0;
		repeat (2) @(negedge clk_i);
		busy = 1'b0;
	endtask
endmodule // host_pins

// file: tb/shift_register_tb.sv
// self-checking bench for the shift register
`timescale 1ns/1ps
module shift_register_tb import shift_pkg::*;;
	logic clk_i, reset_i, snap_ready_i, overflow_clear_i;
	logic shift_clock, load_select, serial_in, s6, s7, s8, known, snap_valid, overflow;
	stage_t parallel_in, exp;
	snapshot_s snap_data;
	int err_count, compares;
	logic [15:0] seed;

	// =====================================================================
	// clock, design and host
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	shift_register DUT (.clk_i(clk_i), .reset_i(reset_i), .shift_clock_i(shift_clock),
		.load_select_i(load_select), .serial_in_i(serial_in), .parallel_in_i(parallel_in),
		.stage6_out_o(s6), .stage7_out_o(s7), .stage8_out_o(s8), .contents_known_o(known),
		.snap_valid_o(snap_valid), .snap_ready_i(snap_ready_i), .snap_data_o(snap_data),
		.overflow_o(overflow), .overflow_clear_i(overflow_clear_i));
	host_pins host (.clk_i(clk_i), .shift_clock_o(shift_clock), .load_select_o(load_select),
		.serial_o(serial_in), .parallel_o(parallel_in));

	// =====================================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected chain after one shift: the new bit enters stage one
	function automatic stage_t shift_in(input stage_t cur, input logic b);
		return {cur[STAGE_COUNT-2:0], b};
	endfunction
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] want);
		compares++;
		if (seen !== want) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// wait for one snapshot, compare it, take it, and expect nothing more
	task automatic take(input op_e op);
		int n;
		n = 0;
		while (snap_valid !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		if (snap_valid !== 1'b1) begin
			check("snapshot wait", {8'h00, snap_valid}, 9'h001);
			wrap_up;
		end else begin
			check("snapshot", snap_data, {op, exp});
			check("outputs", {6'h00, s8, s7, s6}, {6'h00, exp[7:5]});
			snap_ready_i = 1'b1;
			@(negedge clk_i);
			snap_ready_i = 1'b0;
			@(negedge clk_i);
			check("extra snapshot", {8'h00, snap_valid}, 9'h000);
		end
	endtask
	task automatic sh(input logic b, input int hold);
		host.shift(b, hold);
		exp = shift_in(exp, b);
		take(OP_SHIFT);
	endtask
	task automatic ld(input stage_t w);
		host.load(w, 2);
		exp = w;
		take(OP_LOAD);
	endtask

	// =====================================================================
	// main sequence
	initial begin
		err_count = 0;
		compares = 0;
		reset_i = 1'b1;
		snap_ready_i = 1'b0;
		overflow_clear_i = 1'b0;
		seed = 16'hcc55;
		exp = 8'h00;
		repeat (16) @(negedge clk_i);
		reset_i = 1'b0;
		check("known", {8'h00, known}, 9'h000);
		ld(8'h80);
		check("known", {8'h00, known}, 9'h001);
		ld(8'ha5);
		ld(8'h01);
		repeat (7) sh(1'b0, 2);
		repeat (40) begin
			seed = lfsr(seed);
			if (seed[0]) ld(seed[15:8]);
			else sh(seed[1], 2 + seed[2]);
		end
		// flood with the consumer stalled until the buffer refuses
		repeat (20) host.shift(1'b1, 2);
		check("overflow", {8'h00, overflow}, 9'h001);
		overflow_clear_i = 1'b1;
		@(negedge clk_i);
		overflow_clear_i = 1'b0;
		check("overflow clear", {8'h00, overflow}, 9'h000);
		snap_ready_i = 1'b1;
		repeat (40) @(negedge clk_i);
		snap_ready_i = 1'b0;
		check("drained", {8'h00, snap_valid}, 9'h000);
		ld(8'h3c);
		reset_i = 1'b1;
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		check("known", {8'h00, known}, 9'h000);
		ld(8'hc3);
		wrap_up;
	end
endmodule // shift_register_tb
